// ### ivc_ctrl.sv
// Vectored priority interrupt controller with an AXI4-Lite register slave.
`timescale 1ns/1ps
module ivc_ctrl
    import ivc_pkg::*;
#(
    parameter logic [31:0] EXT_MASK  = 32'h0000_0001,
    parameter int          NSYS      = 4,
    parameter logic [31:0] SPUR_VEC  = 32'h0000_00FF // Arbitrary value.
) (
    input  wire logic             mclk_in,             // System clock, never gated.
    input  wire logic             rst_n_in,            // Asynchronous reset, active low.
    input  wire logic             fast_irq_pin_in,     // Fast interrupt pin, source 0.
    input  wire logic [NSYS-1:0]  sys_irq_in,          // System peripheral lines.
    input  wire logic [31:2]      ext_irq_pins_in,     // Sources 2 to 31.
    input  wire logic             s_axi_awvalid_in,    // Write address valid.
    input  wire logic [AW-1:0]    s_axi_awaddr_in,     // Write address.
    input  wire logic             s_axi_wvalid_in,     // Write data valid.
    input  wire logic [31:0]      s_axi_wdata_in,      // Write data.
    input  wire logic [3:0]       s_axi_wstrb_in,      // Write byte strobes.
    input  wire logic             s_axi_bready_in,     // Response ready.
    input  wire logic             s_axi_arvalid_in,    // Read address valid.
    input  wire logic [AW-1:0]    s_axi_araddr_in,     // Read address.
    input  wire logic             s_axi_rready_in,     // Read data ready.
    output logic                  s_axi_awready_out,   // Write address ready.
    output logic                  s_axi_wready_out,    // Write data ready.
    output logic                  s_axi_bvalid_out,    // Write response valid.
    output logic [1:0]            s_axi_bresp_out,     // Write response.
    output logic                  s_axi_arready_out,   // Read address ready.
    output logic                  s_axi_rvalid_out,    // Read data valid.
    output logic [31:0]           s_axi_rdata_out,     // Read data.
    output logic [1:0]            s_axi_rresp_out,     // Read response.
    output logic                  normal_req_out_n,    // Normal request, active low.
    output logic                  fast_req_out_n,      // Fast request, active low.
    output logic                  wake_out             // Processor wake-up.
);
    function automatic logic [31:0] strb_mask(input logic [3:0] s);
        return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction : strb_mask

    logic [4:0]          mode_q [NSRC];
    logic [31:0]         s1_q, s2_q, prev_q, edge_q, imr_q, ffr_q;
    logic                gmask_q;
    logic [31:0]         raw, lvl, is_edge, pol_hi, act_lvl, edge_det, pend, act, fastset, cand;
    logic [31:0]         set_cmd, clr_cmd, aclr, en_cmd, dis_cmd, ffen_cmd, ffdis_cmd;
    logic                best_v;
    logic [PRIO_W-1:0]   best_p;
    logic [NUM_W-1:0]    best_n;
    logic                irq_cond, fiq_cond;
    logic [DEPTH_W-1:0]  depth_q;
    logic [NUM_W-1:0]    cur_num_q;
    logic [PRIO_W-1:0]   cur_prio_q;
    logic [7:0]          stk_rd;
    logic                push, pop;
    ivc_wstate_t         wst_q;
    logic [AW-1:0]       wa_q;
    logic [31:0]         wd_q;
    logic [3:0]          ws_q;
    logic                wr_fire, ar_hs, aw_hs, w_hs, rd_vec, rd_fvec;
    logic [31:0]         wdm, rd_d;
    logic [1:0]          rd_resp, wr_resp;

    // Source 1 merges the system lines; source 0 is the fast pin.
    assign raw = {ext_irq_pins_in, |sys_irq_in, fast_irq_pin_in};

    // Only lines marked external pass through the synchroniser; the pin
    // multiplexer sits outside and contributes no cycles of its own.
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s1_q   <= 32'h0000_0000;
            s2_q   <= 32'h0000_0000;
            prev_q <= 32'h0000_0000;
        end else begin
            s1_q   <= raw;
            s2_q   <= s1_q;
            prev_q <= lvl;
        end
    end

    assign lvl = (EXT_MASK & s2_q) | (~EXT_MASK & raw);

    for (genvar i = 0; i < NSRC; i++) begin : g_src
        assign is_edge[i]  = mode_q[i][PRIO_W];
        assign pol_hi[i]   = mode_q[i][PRIO_W+1] | ~EXT_MASK[i];
        assign act_lvl[i]  = pol_hi[i] ? lvl[i] : ~lvl[i];
        assign edge_det[i] = pol_hi[i] ? (lvl[i] & ~prev_q[i]) : (~lvl[i] & prev_q[i]);
    end

    assign pend    = (is_edge & edge_q) | (~is_edge & act_lvl);
    assign act     = pend & imr_q;
    assign fastset = ffr_q | 32'h0000_0001;
    assign fiq_cond = |(act & fastset);
    assign cand    = act & ~fastset;

    // Highest priority wins; a strict compare keeps the lowest number on a tie.
    always_comb begin
        best_v = 1'b0;
        best_p = '0;
        best_n = '0;
        for (int i = 0; i < NSRC; i++) begin
            if (cand[i] && (!best_v || mode_q[i][PRIO_W-1:0] > best_p)) begin
                best_v = 1'b1;
                best_p = mode_q[i][PRIO_W-1:0];
                best_n = NUM_W'(i);
            end
        end
    end

    assign irq_cond = best_v && (depth_q == '0 || best_p > cur_prio_q);

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            normal_req_out_n <= 1'b1;
            fast_req_out_n   <= 1'b1;
            wake_out         <= 1'b0;
        end else begin
            normal_req_out_n <= !(irq_cond && !gmask_q);
            fast_req_out_n   <= !(fiq_cond && !gmask_q);
            wake_out         <= irq_cond || fiq_cond;
        end
    end

    // Command decode of a committed write.
    assign wdm       = wd_q & strb_mask(ws_q);
    assign set_cmd   = (wr_fire && wa_q == OFS_SET)    ? wdm : 32'h0000_0000;
    assign clr_cmd   = (wr_fire && wa_q == OFS_CLEAR)  ? wdm : 32'h0000_0000;
    assign en_cmd    = (wr_fire && wa_q == OFS_ENABLE) ? wdm : 32'h0000_0000;
    assign dis_cmd   = (wr_fire && wa_q == OFS_DISABLE) ? wdm : 32'h0000_0000;
    assign ffen_cmd  = (wr_fire && wa_q == OFS_FF_EN)  ? wdm : 32'h0000_0000;
    assign ffdis_cmd = (wr_fire && wa_q == OFS_FF_DIS) ? wdm : 32'h0000_0000;
    assign rd_vec    = ar_hs && s_axi_araddr_in == OFS_VECTOR;
    assign rd_fvec   = ar_hs && s_axi_araddr_in == OFS_FVECTOR;
    assign aclr      = ((rd_vec && best_v) ? (32'h0000_0001 << best_n) : 32'h0000_0000)
                     | (rd_fvec ? 32'h0000_0001 : 32'h0000_0000);

    // Edge latches: a new edge or a set wins over any clear in the same cycle.
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            edge_q <= 32'h0000_0000;
        end else begin
            for (int i = 0; i < NSRC; i++) begin
                if (!is_edge[i]) begin
                    edge_q[i] <= 1'b0;
                end else if (edge_det[i] || set_cmd[i]) begin
                    edge_q[i] <= 1'b1;
                end else if (clr_cmd[i] || aclr[i]) begin
                    edge_q[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            imr_q   <= 32'h0000_0000;
            ffr_q   <= 32'h0000_0000;
            gmask_q <= 1'b0;
        end else begin
            imr_q <= (imr_q | en_cmd) & ~dis_cmd;
            ffr_q <= (ffr_q | ffen_cmd) & ~ffdis_cmd;
            if (wr_fire && wa_q == OFS_CTRL && ws_q[0]) begin
                gmask_q <= wd_q[CTRL_GMASK_BIT];
            end
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < NSRC; i++) begin
                mode_q[i] <= MODE_RST;
            end
        end else if (wr_fire && wa_q < OFS_VECTOR && ws_q[0]) begin
            mode_q[wa_q[6:2]] <= {wd_q[MODE_TYPE_LSB+1:MODE_TYPE_LSB],
                                  wd_q[MODE_PRIO_LSB+PRIO_W-1:MODE_PRIO_LSB]};
        end
    end

    // Nesting stack: the top entry sits in registers, older ones in memory.
    assign push = rd_vec && best_v && depth_q < STACK_FULL;
    assign pop  = wr_fire && wa_q == OFS_EOS && depth_q != '0;

    ivc_stack_mem #(
        .DEPTH (STACK_DEPTH),
        .WIDTH (8),
        .AWID  (SP_AW)
    ) u_stack (
        .clk_in      (mclk_in),
        .wr_en_in    (push && depth_q != '0),
        .wr_addr_in  (SP_AW'(depth_q - 4'h1)),
        .wr_data_in  ({cur_num_q, cur_prio_q}),
        .rd_addr_in  (SP_AW'(depth_q - 4'h2)),
        .rd_data_out (stk_rd)
    );

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            depth_q    <= '0;
            cur_num_q  <= '0;
            cur_prio_q <= '0;
        end else if (push) begin
            depth_q    <= depth_q + 4'h1;
            cur_num_q  <= best_n;
            cur_prio_q <= best_p;
        end else if (pop) begin
            depth_q <= depth_q - 4'h1;
            if (depth_q > 4'h1) begin
                {cur_num_q, cur_prio_q} <= stk_rd;
            end else begin
                cur_num_q  <= '0;
                cur_prio_q <= '0;
            end
        end
    end

    // Read data mux; the vector reads sample the ranking at the address handshake.
    always_comb begin
        rd_d    = 32'h0000_0000;
        rd_resp = RESP_OKAY;
        if (s_axi_araddr_in < OFS_VECTOR) begin
            rd_d[MODE_PRIO_LSB+PRIO_W-1:MODE_PRIO_LSB] = mode_q[s_axi_araddr_in[6:2]][PRIO_W-1:0];
            rd_d[MODE_TYPE_LSB+1:MODE_TYPE_LSB] = mode_q[s_axi_araddr_in[6:2]][4:3];
        end else begin
            case (s_axi_araddr_in)
                OFS_VECTOR:   rd_d = best_v ? {27'h0, best_n} : SPUR_VEC;
                OFS_FVECTOR:  rd_d = fiq_cond ? VEC_RST : SPUR_VEC;
                OFS_CURNUM:   rd_d = {27'h0, cur_num_q};
                OFS_PENDING:  rd_d = pend;
                OFS_MASK:     rd_d = imr_q;
                OFS_CORESTAT: rd_d = {30'h0, !normal_req_out_n, !fast_req_out_n};
                OFS_CTRL:     rd_d = {31'h0, gmask_q};
                OFS_FF_STAT:  rd_d = ffr_q;
                OFS_ENABLE, OFS_DISABLE, OFS_CLEAR, OFS_SET, OFS_EOS, OFS_FF_EN, OFS_FF_DIS:
                    rd_d = 32'h0000_0000;
                default:      rd_resp = RESP_SLVERR;
            endcase
        end
    end

    assign ar_hs = s_axi_arvalid_in && s_axi_arready_out;
    assign aw_hs = s_axi_awvalid_in && s_axi_awready_out;
    assign w_hs  = s_axi_wvalid_in && s_axi_wready_out;

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_axi_arready_out <= 1'b1;
            s_axi_rvalid_out  <= 1'b0;
            s_axi_rdata_out   <= 32'h0000_0000;
            s_axi_rresp_out   <= RESP_OKAY;
        end else if (ar_hs) begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out  <= 1'b1;
            s_axi_rdata_out   <= rd_d;
            s_axi_rresp_out   <= rd_resp;
        end else if (s_axi_rvalid_out && s_axi_rready_in) begin
            s_axi_arready_out <= 1'b1;
            s_axi_rvalid_out  <= 1'b0;
        end
    end

    assign wr_fire = wst_q == WS_EXEC;
    always_comb begin
        wr_resp = RESP_SLVERR;
        if (wa_q < OFS_VECTOR || wa_q inside {OFS_ENABLE, OFS_DISABLE, OFS_CLEAR, OFS_SET,
                                              OFS_EOS, OFS_CTRL, OFS_FF_EN, OFS_FF_DIS}) begin
            wr_resp = RESP_OKAY;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wst_q             <= WS_IDLE;
            wa_q              <= '0;
            wd_q              <= 32'h0000_0000;
            ws_q              <= 4'h0;
            s_axi_awready_out <= 1'b1;
            s_axi_wready_out  <= 1'b1;
            s_axi_bvalid_out  <= 1'b0;
            s_axi_bresp_out   <= RESP_OKAY;
        end else begin
            case (wst_q)
                WS_IDLE: begin
                    if (aw_hs) begin
                        wa_q              <= s_axi_awaddr_in;
                        s_axi_awready_out <= 1'b0;
                    end
                    if (w_hs) begin
                        wd_q             <= s_axi_wdata_in;
                        ws_q             <= s_axi_wstrb_in;
                        s_axi_wready_out <= 1'b0;
                    end
                    if ((aw_hs || !s_axi_awready_out) && (w_hs || !s_axi_wready_out)) begin
                        wst_q <= WS_EXEC;
                    end
                end
                WS_EXEC: begin
                    s_axi_bvalid_out <= 1'b1;
                    s_axi_bresp_out  <= wr_resp;
                    wst_q            <= WS_RESP;
                end
                WS_RESP: begin
                    if (s_axi_bready_in) begin
                        s_axi_bvalid_out  <= 1'b0;
                        s_axi_awready_out <= 1'b1;
                        s_axi_wready_out  <= 1'b1;
                        wst_q             <= WS_IDLE;
                    end
                end
                default: wst_q <= WS_IDLE;
            endcase
        end
    end

    chk_fast_drive: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (fiq_cond && !gmask_q) |=> !fast_req_out_n) else $error("fast request not asserted");
    chk_gmask_quiet: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        gmask_q |=> normal_req_out_n && fast_req_out_n) else $error("request under general mask");
    chk_wake_event: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (irq_cond || fiq_cond) |=> wake_out) else $error("wake not raised");
    chk_nest_block: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (depth_q != '0 && best_p <= cur_prio_q) |=> normal_req_out_n) else $error("equal priority reasserted");
    chk_auto_clear: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (rd_vec && best_v && is_edge[best_n] && !edge_det[best_n] && !set_cmd[best_n])
        |=> !edge_q[$past(best_n)]) else $error("vector read left edge latched");
    chk_stack_push: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        push |=> depth_q == $past(depth_q) + 4'h1 && cur_num_q == $past(best_n)) else $error("push failed");
    chk_stack_pop: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        pop |=> depth_q == $past(depth_q) - 4'h1) else $error("pop failed");
    chk_mask_cmd: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        (en_cmd != '0 && dis_cmd == '0) |=> (imr_q & $past(en_cmd)) == $past(en_cmd))
        else $error("enable command lost");
    chk_level_cmd: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        ((set_cmd & ~is_edge) != 32'h0000_0000) |=> (edge_q & $past(set_cmd & ~is_edge)) == 32'h0000_0000)
        else $error("set acted on level source");
endmodule : ivc_ctrl

// ### ivc_pkg.sv
// Shared constants and types of the vectored priority interrupt controller.
package ivc_pkg;
    localparam int AW = 9;
    localparam int NSRC = 32;
    localparam int PRIO_W = 3;
    localparam int NUM_W = 5;
    localparam int STACK_DEPTH = 8;
    localparam int SP_AW = 3;
    localparam int DEPTH_W = 4;
    localparam logic [DEPTH_W-1:0] STACK_FULL = 4'h8;

    // Register byte offsets.
    localparam logic [AW-1:0] OFS_MODE_BASE = 9'h000;
    localparam logic [AW-1:0] OFS_VECTOR    = 9'h100;
    localparam logic [AW-1:0] OFS_FVECTOR   = 9'h104;
    localparam logic [AW-1:0] OFS_CURNUM    = 9'h108;
    localparam logic [AW-1:0] OFS_PENDING   = 9'h10C;
    localparam logic [AW-1:0] OFS_MASK      = 9'h110;
    localparam logic [AW-1:0] OFS_CORESTAT  = 9'h114;
    localparam logic [AW-1:0] OFS_ENABLE    = 9'h120;
    localparam logic [AW-1:0] OFS_DISABLE   = 9'h124;
    localparam logic [AW-1:0] OFS_CLEAR     = 9'h128;
    localparam logic [AW-1:0] OFS_SET       = 9'h12C;
    localparam logic [AW-1:0] OFS_EOS       = 9'h130;
    localparam logic [AW-1:0] OFS_CTRL      = 9'h138;
    localparam logic [AW-1:0] OFS_FF_EN     = 9'h140;
    localparam logic [AW-1:0] OFS_FF_DIS    = 9'h144;
    localparam logic [AW-1:0] OFS_FF_STAT   = 9'h148;

    // Field positions of a source mode register and the control register.
    localparam int MODE_PRIO_LSB = 0;
    localparam int MODE_TYPE_LSB = 5;
    localparam int CTRL_GMASK_BIT = 0;
    localparam logic [4:0] MODE_RST = 5'h00;
    localparam logic [31:0] VEC_RST = 32'h0000_0000;

    // Trigger types: bit 0 selects edge, bit 1 selects high/rising on external lines.
    localparam logic [1:0] TRIG_LOW_LEVEL  = 2'h0;
    localparam logic [1:0] TRIG_FALL_EDGE  = 2'h1;
    localparam logic [1:0] TRIG_HIGH_LEVEL = 2'h2;
    localparam logic [1:0] TRIG_RISE_EDGE  = 2'h3;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        WS_IDLE = 3'h1,
        WS_EXEC = 3'h2,
        WS_RESP = 3'h4
    } ivc_wstate_t;
endpackage : ivc_pkg

// ### ivc_stack_mem.sv
// Nesting stack storage with a registered read port.
`timescale 1ns/1ps
module ivc_stack_mem #(
    parameter int DEPTH = 8,
    parameter int WIDTH = 8,
    parameter int AWID  = 3
) (
    input  wire logic             clk_in,      // System clock.
    input  wire logic             wr_en_in,    // Write strobe.
    input  wire logic [AWID-1:0]  wr_addr_in,  // Write address.
    input  wire logic [WIDTH-1:0] wr_data_in,  // Write data.
    input  wire logic [AWID-1:0]  rd_addr_in,  // Read address.
    output logic      [WIDTH-1:0] rd_data_out  // Registered read data.
);
    logic [WIDTH-1:0] mem_q [DEPTH];

    always_ff @(posedge clk_in) begin
        if (wr_en_in) begin
            mem_q[wr_addr_in] <= wr_data_in;
        end
        rd_data_out <= mem_q[rd_addr_in];
    end
endmodule : ivc_stack_mem

// ### ivc_core_model.sv
// Processor core model that counts entries on the normal request.
`timescale 1ns/1ps
module ivc_core_model (
    input  wire logic       clk_in,     // System clock.
    input  wire logic       rst_n_in,   // Reset, active low.
    input  wire logic       irq_n_in,   // Normal request, active low.
    output logic      [7:0] entries_out // Handler entries seen.
);
    logic irq_n_q;
    // A falling request wakes the core and enters its handler once.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_n_q     <= 1'b1;
            entries_out <= 8'h00;
        end else begin
            irq_n_q <= irq_n_in;
            if (irq_n_q && !irq_n_in) entries_out <= entries_out + 8'h01;
        end
    end
endmodule : ivc_core_model

// ### ivc_ctrl_tb_top.sv
// Self-checking testbench of the vectored priority interrupt controller.
`timescale 1ns/1ps
module ivc_ctrl_tb_top
    import ivc_pkg::*;
;
    logic          mclk = 1'b0, rst_n = 1'b0, fpin = 1'b1;
    logic [31:2]   ext = 30'h0;
    logic          awv = 1'b0, wv = 1'b0, arv = 1'b0;
    logic [AW-1:0] awaddr = 9'h0, araddr = 9'h0;
    logic [31:0]   wdata = 32'h0, rdat, rdata;
    logic [1:0]    rrsp, bresp, rresp;
    logic          awready, wready, bvalid, arready, rvalid, nreq_n, freq_n, wake;
    logic [3:0]    system_source = 4'h0;
    logic [7:0]    entries;
    int            bad_count = 0, total_checks = 0, pa, pb;
    logic [31:0]   w;
    always #4 mclk = ~mclk;
    ivc_ctrl u_dut (.mclk_in(mclk), .rst_n_in(rst_n), .fast_irq_pin_in(fpin), .sys_irq_in(system_source),
        .ext_irq_pins_in(ext), .s_axi_awvalid_in(awv), .s_axi_awaddr_in(awaddr), .s_axi_wvalid_in(wv),
        .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_bready_in(1'b1), .s_axi_arvalid_in(arv),
        .s_axi_araddr_in(araddr), .s_axi_rready_in(1'b1), .s_axi_awready_out(awready),
        .s_axi_wready_out(wready), .s_axi_bvalid_out(bvalid), .s_axi_bresp_out(bresp),
        .s_axi_arready_out(arready), .s_axi_rvalid_out(rvalid), .s_axi_rdata_out(rdata),
        .s_axi_rresp_out(rresp), .normal_req_out_n(nreq_n), .fast_req_out_n(freq_n), .wake_out(wake));
    ivc_core_model u_core (.clk_in(mclk), .rst_n_in(rst_n), .irq_n_in(nreq_n), .entries_out(entries));
    task automatic final_report;
        $display("Checks %0d, errors %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : final_report
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
    endtask : wt
    // Ready lines are held high, so only valid and payload move.
    task automatic axw(input logic [AW-1:0] a, input logic [31:0] d);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
            if (awv && awready) awv <= 1'b0;
            if (wv && wready) wv <= 1'b0;
        end while (bvalid !== 1'b1 && n < 100);
        if (n >= 100) bad_count++;
    endtask : axw
    task automatic axr(input logic [AW-1:0] a);
        int n;
        n = 0;
        araddr <= a;
        arv <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
            if (arv && arready) arv <= 1'b0;
            rdat = rdata;
            rrsp = rresp;
        end while (rvalid !== 1'b1 && n < 100);
        if (n >= 100) bad_count++;
    endtask : axr
    function automatic logic [31:0] winner(input int a, input int b);
        return (b > a) ? 32'h0000_000B : 32'h0000_000A;
    endfunction : winner
    initial begin
        void'($urandom(41));
        wt(3);
        rst_n <= 1'b1;
        wt(1);
        chk("normal_req", 32'h1, nreq_n);
        chk("fast_req", 32'h1, freq_n);
        axr(OFS_MASK);
        chk("mask", 32'h0, rdat);
        axw(OFS_MODE_BASE + 9'h014, 32'h3);
        axw(OFS_ENABLE, 32'h20);
        axr(OFS_MASK);
        chk("mask", 32'h20, rdat);
        ext[5] <= 1'b1;
        wt(3);
        chk("normal_req", 32'h0, nreq_n);
        axr(OFS_PENDING);
        chk("pending", 32'h20, rdat);
        axr(OFS_VECTOR);
        chk("vector", 32'h5, rdat);
        wt(3);
        chk("normal_req", 32'h1, nreq_n);
        axr(OFS_CURNUM);
        chk("current_number", 32'h5, rdat);
        axw(OFS_EOS, 32'h0);
        wt(3);
        chk("normal_req", 32'h0, nreq_n);
        ext[5] <= 1'b0;
        wt(3);
        axw(OFS_SET, 32'h20);
        axr(OFS_PENDING);
        chk("pending", 32'h0, rdat);
        axw(OFS_DISABLE, 32'h20);
        ext[5] <= 1'b1;
        axw(OFS_ENABLE, 32'hC00);
        for (int i = 0; i < 3; i++) begin
            pa = $urandom % 8;
            pb = (i == 0) ? pa : $urandom % 8;
            axw(OFS_MODE_BASE + 9'h028, 32'h20 | pa);
            axw(OFS_MODE_BASE + 9'h02C, 32'h20 | pb);
            axw(OFS_SET, 32'hC00);
            w = winner(pa, pb);
            axr(OFS_VECTOR);
            chk("vector", w, rdat);
            axr(OFS_PENDING);
            chk("pending", (32'h1 << (21 - w)) | 32'h20, rdat & 32'hC20);
            axw(OFS_EOS, 32'h0);
            axr(OFS_VECTOR);
            chk("vector", 32'h15 - w, rdat);
            axw(OFS_EOS, 32'h0);
        end
        ext[5] <= 1'b0;
        axw(OFS_ENABLE, 32'h1);
        fpin <= 1'b0;
        wt(5);
        chk("fast_req", 32'h0, freq_n);
        axr(OFS_CORESTAT);
        chk("core_status", 32'h1, rdat);
        axr(OFS_FVECTOR);
        chk("fast_vector", 32'h0, rdat);
        fpin <= 1'b1;
        axr(9'h1FC);
        chk("unmapped_resp", RESP_SLVERR, rrsp);
        system_source <= 4'h4;
        axw(OFS_MODE_BASE, 32'h20);
        axw(OFS_SET, 32'h1);
        axw(OFS_CTRL, 32'h1);
        wt(2);
        chk("fast_req", 32'h1, freq_n);
        chk("wake", 32'h1, wake);
        axw(OFS_CTRL, 32'h0);
        axr(OFS_FVECTOR);
        chk("fast_vector", 32'h0, rdat);
        axw(OFS_FF_EN, 32'h400);
        axw(OFS_SET, 32'h400);
        axr(OFS_VECTOR);
        chk("vector", 32'hFF, rdat);
        axr(OFS_PENDING);
        chk("pending", 32'h402, rdat);
        chk("core_entries", 32'h8, entries);
        final_report;
    end
    initial begin
        #100000;
        bad_count++;
        final_report;
    end
endmodule : ivc_ctrl_tb_top
